// >>> design/fpc_defines.vh
// Constants for the flash protect/status host controller
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH
`define FPC_ADDR_CTRL 4'h0
`define FPC_ADDR_TARGET 4'h1
`define FPC_ADDR_DATA 4'h2
`define FPC_ADDR_STATUS 4'h3
`define FPC_ADDR_FLASH_SR 4'h4
`define FPC_ADDR_PINS 4'h5
`define FPC_CTRL_GO_ERASE 0
`define FPC_CTRL_GO_WRITE 1
`define FPC_CTRL_CLEAR_SR 2
`define FPC_CTRL_READ_ARRAY 3
`define FPC_CTRL_SUSPEND 4
`define FPC_CTRL_RESUME 5
`define FPC_CTRL_RUN_PD 6
`define FPC_PINS_WP_N 0
`define FPC_PINS_OVERRIDE 1
`define FPC_PINS_VPP_EN 2
`define FPC_CMD_ERASE_SETUP 8'h20
`define FPC_CMD_CONFIRM 8'hD0
`define FPC_CMD_WRITE_SETUP 8'h40
`define FPC_CMD_READ_ARRAY 8'hFF
`define FPC_CMD_CLEAR_SR 8'h50
`define FPC_CMD_READ_SR 8'h70
`define FPC_CMD_SUSPEND 8'hB0
`define FPC_SR_READY 7
`define FPC_SR_ERASE_PAUSED 6
`define FPC_SR_ERASE_FAIL 5
`define FPC_SR_PROG_FAIL 4
`define FPC_SR_SUPPLY_LOW 3
`define FPC_SR_PROG_PAUSED 2
`define FPC_SR_LOCK_ABORT 1
`define FPC_SR_VALID_MASK 8'hFE
`define FPC_SR_RESET 8'h80
`define FPC_BUS_CYCLES 3'h4
`endif

// >>> design/fpc_host.v
// Host controller driving a boot-block flash write engine over its bus pins
// Operation
// - Bits 5 and 4 both set after erase means bad command sequence.
// - Host masks reserved status bit 0 whenever polling.
// - Erase is setup code then confirm code at the block address.
// - Host polls bit 7 until ready; may repeat erasures before checking.
// - Host writes read-array code after the last operation; the controller sends it only when CTRL bit 3 is written.
// - Host clears status on any error before retry or recovery; the controller accepts commands with errors set.
`timescale 1ns/1ps
`include "fpc_defines.vh"
module fpc_host (
  input wire i_core_clk,
  input wire i_rst,
  input wire [3:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [31:0] o_reg_rdata,
  output reg [19:0] o_flash_addr,
  output reg [7:0] o_flash_dq,
  output reg o_flash_dq_oe,
  input wire [7:0] i_flash_dq,
  output reg o_flash_ce_n,
  output reg o_flash_we_n,
  output reg o_flash_oe_n,
  output reg o_flash_wp_n,
  output reg o_flash_reset_low_n,
  output reg o_flash_reset_override,
  output reg o_flash_prog_supply_en,
  input wire i_ready_busy_out
);

  localparam ST_IDLE = 4'h0;
  localparam ST_WR = 4'h1;
  localparam ST_POLL = 4'h2;
  localparam ST_RD = 4'h3;
  localparam ST_DONE = 4'h4;

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [7:0] seq_ff [0:1];
  reg [1:0] seq_len_ff;
  reg [1:0] seq_idx_ff;
  reg [2:0] cyc_ff;
  reg [19:0] target_ff;
  reg [7:0] data_ff;
  reg [7:0] op_status_reg_ff;
  reg busy_ff;
  reg poll_ff;
  reg seq_err_ff;
  reg any_err_ff;
  reg [2:0] rb_sync_ff;
  reg rb_ff;
  reg pd_ff;
  reg [7:0] dq_s1_ff;
  reg [7:0] dq_s2_ff;
  reg [7:0] dq_s3_ff;
  wire [7:0] masked_sr;
  wire [7:0] ctrl;

  assign ctrl = i_reg_wdata[7:0];
  assign masked_sr = dq_s3_ff & `FPC_SR_VALID_MASK;

  // Three-stage pin sync; change counts when stages two and three agree
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      rb_sync_ff <= 3'h7;
      rb_ff <= 1'b1;
    end else begin
      rb_sync_ff <= {rb_sync_ff[1:0], i_ready_busy_out};
      if (rb_sync_ff[1] == rb_sync_ff[2])
        rb_ff <= rb_sync_ff[2];
    end
  end

  // Data pins come from the flash; three stages like the ready pin
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
      dq_s3_ff <= 8'h00;
    end else begin
      dq_s1_ff <= i_flash_dq;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
    end
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (seq_len_ff != 2'h0)
          nxt_state = ST_WR;
      end
      ST_WR: begin
        if (cyc_ff == `FPC_BUS_CYCLES) begin
          if (seq_idx_ff + 2'h1 < seq_len_ff)
            nxt_state = ST_WR;
          else if (poll_ff)
            nxt_state = ST_RD;
          else
            nxt_state = ST_DONE;
        end
      end
      ST_RD: begin
        if (cyc_ff == `FPC_BUS_CYCLES)
          nxt_state = ST_POLL;
      end
      ST_POLL: begin
        if (op_status_reg_ff[`FPC_SR_READY])
          nxt_state = ST_DONE;
        else
          nxt_state = ST_RD;
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      seq_ff[0] <= 8'h00;
      seq_ff[1] <= 8'h00;
      seq_len_ff <= 2'h0;
      seq_idx_ff <= 2'h0;
      cyc_ff <= 3'h0;
      target_ff <= 20'h00000;
      data_ff <= 8'h00;
      op_status_reg_ff <= `FPC_SR_RESET;
      busy_ff <= 1'b0;
      poll_ff <= 1'b0;
      seq_err_ff <= 1'b0;
      any_err_ff <= 1'b0;
      pd_ff <= 1'b0;
      o_reg_rdata <= 32'h00000000;
      o_flash_addr <= 20'h00000;
      o_flash_dq <= 8'h00;
      o_flash_dq_oe <= 1'b0;
      o_flash_ce_n <= 1'b1;
      o_flash_we_n <= 1'b1;
      o_flash_oe_n <= 1'b1;
      o_flash_wp_n <= 1'b0;
      o_flash_reset_low_n <= 1'b1;
      o_flash_reset_override <= 1'b0;
      o_flash_prog_supply_en <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_reg_rdata <= 32'h00000000;
      if (i_reg_rd) begin
        if (i_reg_addr == `FPC_ADDR_TARGET)
          o_reg_rdata <= {12'h000, target_ff};
        else if (i_reg_addr == `FPC_ADDR_DATA)
          o_reg_rdata <= {24'h000000, data_ff};
        else if (i_reg_addr == `FPC_ADDR_STATUS)
          o_reg_rdata <= {27'h0, pd_ff, any_err_ff, seq_err_ff, rb_ff,
                          busy_ff};
        else if (i_reg_addr == `FPC_ADDR_FLASH_SR)
          o_reg_rdata <= {24'h000000, op_status_reg_ff};
        else if (i_reg_addr == `FPC_ADDR_PINS)
          o_reg_rdata <= {29'h0, o_flash_prog_supply_en,
                          o_flash_reset_override, o_flash_wp_n};
      end
      if (i_reg_wr) begin
        if (i_reg_addr == `FPC_ADDR_TARGET)
          target_ff <= i_reg_wdata[19:0];
        else if (i_reg_addr == `FPC_ADDR_DATA)
          data_ff <= i_reg_wdata[7:0];
        else if (i_reg_addr == `FPC_ADDR_PINS) begin
          o_flash_wp_n <= i_reg_wdata[`FPC_PINS_WP_N];
          o_flash_reset_override <= i_reg_wdata[`FPC_PINS_OVERRIDE];
          o_flash_prog_supply_en <= i_reg_wdata[`FPC_PINS_VPP_EN];
        end else if (i_reg_addr == `FPC_ADDR_CTRL && !busy_ff) begin
          busy_ff <= 1'b1;
          seq_idx_ff <= 2'h0;
          poll_ff <= 1'b0;
          seq_len_ff <= 2'h1;
          if (ctrl[`FPC_CTRL_GO_ERASE]) begin
            seq_ff[0] <= `FPC_CMD_ERASE_SETUP;
            seq_ff[1] <= `FPC_CMD_CONFIRM;
            seq_len_ff <= 2'h2;
            poll_ff <= 1'b1;
          end else if (ctrl[`FPC_CTRL_GO_WRITE]) begin
            seq_ff[0] <= `FPC_CMD_WRITE_SETUP;
            seq_ff[1] <= data_ff;
            seq_len_ff <= 2'h2;
            poll_ff <= 1'b1;
          end else if (ctrl[`FPC_CTRL_CLEAR_SR]) begin
            seq_ff[0] <= `FPC_CMD_CLEAR_SR;
            any_err_ff <= 1'b0;
            seq_err_ff <= 1'b0;
          end else if (ctrl[`FPC_CTRL_READ_ARRAY]) begin
            seq_ff[0] <= `FPC_CMD_READ_ARRAY;
          end else if (ctrl[`FPC_CTRL_SUSPEND]) begin
            seq_ff[0] <= `FPC_CMD_SUSPEND;
            poll_ff <= 1'b1;
          end else if (ctrl[`FPC_CTRL_RESUME]) begin
            seq_ff[0] <= `FPC_CMD_CONFIRM;
          end else if (ctrl[`FPC_CTRL_RUN_PD]) begin
            seq_len_ff <= 2'h0;
            busy_ff <= 1'b0;
            pd_ff <= ~pd_ff;
            o_flash_reset_low_n <= pd_ff;
            if (!pd_ff)
              op_status_reg_ff <= `FPC_SR_RESET;
          end else begin
            seq_len_ff <= 2'h0;
            busy_ff <= 1'b0;
          end
        end
      end
      case (state_ff)
        ST_IDLE: begin
          cyc_ff <= 3'h0;
          o_flash_ce_n <= 1'b1;
          o_flash_we_n <= 1'b1;
          o_flash_oe_n <= 1'b1;
          o_flash_dq_oe <= 1'b0;
        end
        ST_WR: begin
          cyc_ff <= cyc_ff + 3'h1;
          o_flash_addr <= target_ff;
          o_flash_dq <= seq_ff[seq_idx_ff[0]];
          o_flash_dq_oe <= 1'b1;
          o_flash_ce_n <= 1'b0;
          o_flash_we_n <= (cyc_ff == 3'h0 || cyc_ff >= 3'h3);
          if (cyc_ff == `FPC_BUS_CYCLES) begin
            cyc_ff <= 3'h0;
            seq_idx_ff <= seq_idx_ff + 2'h1;
            o_flash_ce_n <= 1'b1;
            o_flash_dq_oe <= 1'b0;
          end
        end
        ST_RD: begin
          cyc_ff <= cyc_ff + 3'h1;
          o_flash_ce_n <= 1'b0;
          o_flash_oe_n <= 1'b0;
          o_flash_dq_oe <= 1'b0;
          if (cyc_ff == `FPC_BUS_CYCLES) begin
            cyc_ff <= 3'h0;
            o_flash_ce_n <= 1'b1;
            o_flash_oe_n <= 1'b1;
            // Lower bits only when ready
            // Stages that disagree mean data still moving: poll again
            if (dq_s2_ff == dq_s3_ff && dq_s3_ff[`FPC_SR_READY])
              op_status_reg_ff <= masked_sr;
            else
              op_status_reg_ff <= 8'h00;
          end
        end
        ST_DONE: begin
          busy_ff <= 1'b0;
          seq_len_ff <= 2'h0;
          if (poll_ff) begin
            // Both fail bits mean bad sequence
            if (op_status_reg_ff[`FPC_SR_ERASE_FAIL] &&
                op_status_reg_ff[`FPC_SR_PROG_FAIL])
              seq_err_ff <= 1'b1;
            if (op_status_reg_ff[`FPC_SR_ERASE_FAIL] ||
                op_status_reg_ff[`FPC_SR_PROG_FAIL] ||
                op_status_reg_ff[`FPC_SR_SUPPLY_LOW] ||
                op_status_reg_ff[`FPC_SR_LOCK_ABORT])
              any_err_ff <= 1'b1;
          end
        end
        default: cyc_ff <= 3'h0;
      endcase
    end
  end

endmodule

// >>> verif/fpc_host_chk.sv
// Assertions on the flash host controller ports
`timescale 1ns/1ps
module fpc_host_chk (
  input wire i_core_clk,
  input wire i_rst,
  input wire [3:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [31:0] o_reg_rdata,
  input wire [19:0] o_flash_addr,
  input wire [7:0] o_flash_dq,
  input wire o_flash_dq_oe,
  input wire [7:0] i_flash_dq,
  input wire o_flash_ce_n,
  input wire o_flash_we_n,
  input wire o_flash_oe_n,
  input wire o_flash_wp_n,
  input wire o_flash_reset_low_n,
  input wire o_flash_reset_override,
  input wire o_flash_prog_supply_en,
  input wire i_ready_busy_out
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_rd_idle; !$past(i_reg_rd) |-> o_reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray data");
  property p_unmap;
    $past(i_reg_rd) && $past(i_reg_addr) > 4'h5 |-> o_reg_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_pins_rd; $past(i_reg_rd) && $past(i_reg_addr) == 4'h5 |->
    o_reg_rdata[2:0] == {o_flash_prog_supply_en, o_flash_reset_override,
    o_flash_wp_n}; endproperty
  a_pins_rd: assert property (p_pins_rd) else $error("pin readback");
  property p_pins_wr; i_reg_wr && i_reg_addr == 4'h5 |=>
    {o_flash_prog_supply_en, o_flash_reset_override, o_flash_wp_n} ==
    $past(i_reg_wdata[2:0]); endproperty
  a_pins_wr: assert property (p_pins_wr) else $error("pin write");
  // Host and flash never drive data together
  property p_fight; !(o_flash_dq_oe && !o_flash_oe_n); endproperty
  a_fight: assert property (p_fight) else $error("data contention");
  property p_we_sel;
    !o_flash_we_n |-> !o_flash_ce_n && o_flash_dq_oe;
  endproperty
  a_we_sel: assert property (p_we_sel) else $error("bad select");
  property p_we_len; $fell(o_flash_we_n) |=> !o_flash_we_n ##1 o_flash_we_n;
  endproperty
  a_we_len: assert property (p_we_len) else $error("write pulse");
  property p_confirm; $fell(o_flash_we_n) && o_flash_dq == 8'h20 |->
    ##[4:20] ($fell(o_flash_we_n) && o_flash_dq == 8'hD0); endproperty
  a_confirm: assert property (p_confirm) else $error("no confirm");
  property p_addr; !o_flash_ce_n && !$past(o_flash_ce_n) |->
    $stable(o_flash_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  c_erase: cover property ($fell(o_flash_we_n) && o_flash_dq == 8'h20);
  c_unmap: cover property (i_reg_rd && i_reg_addr > 4'h5);
  c_pins: cover property (i_reg_wr && i_reg_addr == 4'h5);
endmodule
bind fpc_host fpc_host_chk fpc_host_chk_i (.i_core_clk, .i_rst, .i_reg_addr,
  .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_flash_addr,
  .o_flash_dq, .o_flash_dq_oe, .i_flash_dq, .o_flash_ce_n, .o_flash_we_n,
  .o_flash_oe_n, .o_flash_wp_n, .o_flash_reset_low_n,
  .o_flash_reset_override, .o_flash_prog_supply_en, .i_ready_busy_out);

// >>> verif/fpc_flash_model.sv
// Behavioural boot-block flash write engine
`timescale 1ns/1ps
module fpc_flash_model (
  input wire i_core_clk,
  input wire i_rst,
  input wire [19:0] i_addr,
  input wire [7:0] i_dq,
  input wire i_ce_n,
  input wire i_we_n,
  input wire i_oe_n,
  input wire i_wp_n,
  input wire i_rlow_n,
  input wire i_ovr,
  input wire i_vpp,
  output wire [7:0] o_dq,
  output wire o_rb
);
  reg [7:0] sr_ff;
  reg [1:0] pend_ff;
  reg st_ff;
  reg we_ff;
  reg [7:0] cnt_ff;
  reg [7:0] last_ff;
  reg [7:0] e;
  wire rd = !i_ce_n && !i_oe_n;
  wire boot = &i_addr[19:14];
  wire lock = boot && !i_wp_n && !i_ovr;
  // Bit 0 set so the host must mask it; idle bus shows junk
  assign o_dq = rd ? (st_ff ? {sr_ff[7:1], 1'b1} : 8'hFF) : ~last_ff;
  assign o_rb = sr_ff[7] || !i_rlow_n;
  always @(posedge i_core_clk) begin
    we_ff <= i_we_n;
    if (rd) last_ff <= o_dq;
    if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    if (cnt_ff == 8'h01) sr_ff[7] <= 1'b1;
    if (i_rst || !i_rlow_n) begin
      sr_ff <= 8'h80;
      pend_ff <= 2'h0;
      st_ff <= 1'b0;
      cnt_ff <= 8'h00;
      last_ff <= 8'h00;
    end else if (!we_ff && i_we_n && !i_ce_n) begin
      st_ff <= 1'b1;
      pend_ff <= 2'h0;
      if (pend_ff != 2'h0) begin
        e = pend_ff[0] ? 8'h20 : 8'h10;
        if (pend_ff[0] && i_dq != 8'hD0) e = 8'h30;
        else if (!i_vpp) e = e | 8'h08;
        else if (lock) e = e | 8'h02;
        else e = 8'h00;
        sr_ff <= (sr_ff | e) & 8'h7F;
        cnt_ff <= 8'h14;
      end else if (i_dq == 8'h20) pend_ff <= 2'h1;
      else if (i_dq == 8'h40) pend_ff <= 2'h2;
      else if (i_dq == 8'h50) sr_ff[5:1] <= 5'h00;
      // Idle engine pauses at once; no pause bit shows
      else if (i_dq == 8'hB0)
        sr_ff <= {2'h2, sr_ff[5:3], 1'b0, sr_ff[1:0]};
      else if (i_dq == 8'hFF) st_ff <= 1'b0;
    end
  end
endmodule

// >>> verif/fpc_host_bench.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "fpc_defines.vh"
module fpc_host_bench;
  reg i_core_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [3:0] i_reg_addr = 4'h0;
  reg [31:0] i_reg_wdata = 32'h0;
  reg i_reg_wr = 1'b0;
  reg i_reg_rd = 1'b0;
  wire [31:0] o_reg_rdata;
  wire [19:0] o_flash_addr;
  wire [7:0] o_flash_dq, i_flash_dq, m_dq;
  wire o_flash_dq_oe, o_flash_ce_n, o_flash_we_n, o_flash_oe_n;
  wire o_flash_wp_n, o_flash_reset_low_n, o_flash_reset_override;
  wire o_flash_prog_supply_en, i_ready_busy_out;
  integer fail_count = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer k;
  reg [31:0] d;
  reg [31:0] tab [0:6];
  assign i_flash_dq = o_flash_dq_oe ? o_flash_dq : m_dq;
  always #5 i_core_clk = ~i_core_clk;
  fpc_host fpc_host_i (.i_core_clk, .i_rst, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_flash_addr, .o_flash_dq,
    .o_flash_dq_oe, .i_flash_dq, .o_flash_ce_n, .o_flash_we_n,
    .o_flash_oe_n, .o_flash_wp_n, .o_flash_reset_low_n,
    .o_flash_reset_override, .o_flash_prog_supply_en, .i_ready_busy_out);
  fpc_flash_model m_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_addr(o_flash_addr), .i_dq(i_flash_dq), .i_ce_n(o_flash_ce_n),
    .i_we_n(o_flash_we_n), .i_oe_n(o_flash_oe_n), .i_wp_n(o_flash_wp_n),
    .i_rlow_n(o_flash_reset_low_n), .i_ovr(o_flash_reset_override),
    .i_vpp(o_flash_prog_supply_en), .o_dq(m_dq), .o_rb(i_ready_busy_out));
  task chk(input [31:0] s, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] v);
    begin
      @(posedge i_core_clk);
      i_reg_addr <= a;
      i_reg_wdata <= v;
      i_reg_wr <= 1'b1;
      @(posedge i_core_clk);
      i_reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge i_core_clk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_core_clk);
      i_reg_rd <= 1'b0;
      #1 d = o_reg_rdata;
    end
  endtask
  // Command then poll busy; busy left over after the budget is a mismatch
  task op(input [31:0] c);
    begin
      wr(`FPC_ADDR_CTRL, c);
      d = 32'h1;
      repeat (200) if (d[0] !== 1'b0) rd(`FPC_ADDR_STATUS);
      chk(d[0], 1'b0);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge i_core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  initial begin
    // Pins, command, expected status, target block
    tab[0] = 32'h0001A8FF;
    tab[1] = 32'h000298FF;
    tab[2] = 32'h040292FF;
    tab[3] = 32'h0401A2FF;
    tab[4] = 32'h04018000;
    tab[5] = 32'h050280FF;
    tab[6] = 32'h060180FF;
    repeat (3) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(`FPC_ADDR_FLASH_SR);
    chk(d, 32'h80);
    rd(`FPC_ADDR_PINS);
    chk(d, 32'h0);
    rd(4'hF);
    chk(d, 32'h0);
    for (k = 0; k < 7; k = k + 1) begin
      wr(`FPC_ADDR_PINS, tab[k][31:24]);
      wr(`FPC_ADDR_TARGET, {tab[k][7:0], 12'h000});
      op(32'h4);
      op(tab[k][23:16]);
      rd(`FPC_ADDR_FLASH_SR);
      chk(d, tab[k][15:8]);
    end
    wr(`FPC_ADDR_PINS, 32'h4);
    op(32'h1);
    op(32'h2);
    rd(`FPC_ADDR_FLASH_SR);
    chk(d, 32'hB2);
    rd(`FPC_ADDR_STATUS);
    chk(d[3:2], 2'h3);
    op(32'h4);
    rd(`FPC_ADDR_STATUS);
    chk(d[3:2], 2'h0);
    op(32'h8);
    chk(m_i.st_ff, 1'b0);
    // Locked erase leaves error bits in the flash before power-down
    op(32'h1);
    op(32'h40);
    chk({o_flash_reset_low_n, i_ready_busy_out}, 2'h1);
    chk(d, 32'h1A);
    rd(`FPC_ADDR_FLASH_SR);
    chk(d, 32'h80);
    op(32'h40);
    chk(o_flash_reset_low_n, 1'b1);
    // Suspend polls the flash: its errors must be gone after power-down
    op(32'h10);
    rd(`FPC_ADDR_FLASH_SR);
    chk(d, 32'h80);
    op(32'h20);
    chk(d, 32'h0A);
    end_of_test;
  end
endmodule
